// ---- hdl/occ_bank.sv ----
/*
  Output clock configuration bank for one channel: APB register
  slave, decode of divide ratio, delays, pin mode, driver standard
  and supply level, and the pin router for the channel's two pins.

  Register map (index, byte address = index * 4, fields):
    0x46 drv std     [2:0] driver standard, [7:3] spare
    0x47 pin mode    [7:6] ratio bits 33:32, [5] spare,
                     [4] fine delay bit 2, [3:0] pin configuration
    0x48 ratio high  [3:0] ratio bits 19:16, [7:4] spare
    0x49 ratio mid   [7:0] ratio bits 15:8
    0x4A ratio low   [7:0] ratio bits 7:0
    0x4B phase/str   [7:6] single-ended phase, [2:0] drive strength
    0x4C delay       [7:6] fine delay code, [5:0] coarse delay
    0x4D supply      [4:3] supply level, others spare
  Every bit is stored and read back; spare bits have no effect.

  Bus timing: the setup edge latches read data and the error flag,
  so pready stays high and the bank never inserts a wait state.
  A write lands at the access edge; the decoded cfg follows one
  edge later, and the pins follow cfg without a further edge.
  Unaligned or unmapped addresses answer with pslverr and read
  data zero, and a write to them is dropped. A clear low byte
  strobe drops a write quietly, without an error.

  Decoded outputs: cfg.config_error is high for an illegal pin
  configuration, the reserved supply code or a reserved driver
  code. An illegal pin configuration also switches both pin
  drivers off, so a bad write cannot fight an external load.
  Fine delay codes above four clamp to four steps on the
  extended channel. With EXT_RANGE clear, the extension bits
  are still stored and read back, but the decode ignores them.

  Reset: every register and every cfg field is zero, which
  decodes to differential with external termination, so both
  pins drive as soon as the channel clocks run.

  Pin steering: the pin paths are combinational from the clock
  inputs; a flop would only resample the clock. The price is
  that a pin may glitch in the cycle in which its mode or phase
  changes, so software should change them with the output idle.

  Assumes a 10 MHz pclk, an APB master on the same clock and clock
  inputs from the channel's divider in the analogue section.

*/
`timescale 1ns/1ps
`include "occ_regs.svh"

module occ_bank #(
  parameter int ADDR_W = 12,
  parameter bit EXT_RANGE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic true_clock,
  input wire logic complement_clock,
  output occ_pkg::occ_cfg_t cfg,
  output occ_pkg::occ_pins_t pins
);
  import occ_pkg::*;

  // Whole bank state and its next value
  occ_state_t state_ff;
  occ_state_t nxt_state;

  // Decode of the transfer now on the bus
  logic setup_phase;
  logic access_phase;
  logic addr_aligned;
  logic [7:0] word_index;
  logic addr_hit;
  logic [7:0] read_byte;
  logic wr_en;

  // Word index of a byte address; upper bits beyond 8 must be zero
  function automatic logic [7:0] index_of(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] shifted;
    shifted = addr >> 2;
    if (shifted > ADDR_W'(8'hFF)) begin
      index_of = 8'hFF;
    end else begin
      index_of = shifted[7:0];
    end
  endfunction : index_of

  // True when the index names one of the bank's registers
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= `OCC_IDX_DRV_STD) && (idx <= `OCC_IDX_SUPPLY);
  endfunction : is_mapped

  // Read mux over the raw registers; spare bits read as stored
  function automatic logic [7:0] read_reg(input occ_regfile_t r,
                                           input logic [7:0] idx);
    unique case (idx)
      `OCC_IDX_DRV_STD: read_reg = r.drv_std;
      `OCC_IDX_PIN_MODE: read_reg = r.pin_mode;
      `OCC_IDX_RATIO_HIGH: read_reg = r.ratio_high;
      `OCC_IDX_RATIO_MID: read_reg = r.ratio_mid;
      `OCC_IDX_RATIO_LOW: read_reg = r.ratio_low;
      `OCC_IDX_PHASE_STR: read_reg = r.phase_str;
      `OCC_IDX_DELAY: read_reg = r.delay;
      `OCC_IDX_SUPPLY: read_reg = r.supply;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Low-nibble pin configuration decode; other codes are illegal
  function automatic occ_pin_mode_t decode_pins(input logic [3:0] code);
    unique case (code)
      4'h0: decode_pins = OCC_PIN_DIFF_EXT;
      4'h2: decode_pins = OCC_PIN_DIFF_PULLUP;
      4'h4: decode_pins = OCC_PIN_SE_POS;
      4'h8: decode_pins = OCC_PIN_SE_NEG;
      4'hC: decode_pins = OCC_PIN_SE_BOTH;
      default: decode_pins = OCC_PIN_INVALID;
    endcase
  endfunction : decode_pins

  // Byte-wide register write honouring the low byte strobe
  function automatic logic [7:0] write_byte(input logic [7:0] old,
                                             input logic [31:0] wdata,
                                             input logic strb);
    write_byte = strb ? wdata[7:0] : old;
  endfunction : write_byte

  // APB phase and address decode
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign word_index = index_of(paddr);
  assign addr_hit = addr_aligned && is_mapped(word_index);
  assign read_byte = read_reg(state_ff.regs, word_index);
  // Writes land at the access edge; pready is always high there
  assign wr_en = access_phase && pwrite && addr_hit && !state_ff.pslverr;

  // Next-state logic: register writes, read data, decode
  always_comb begin
    nxt_state = state_ff;

    // Read data and error are captured in setup, so both come
    // from flops yet the bank still answers with no wait state
    if (setup_phase) begin
      nxt_state.pslverr = !addr_hit;
      nxt_state.prdata = (!pwrite && addr_hit) ? {24'h0, read_byte} : 32'h0;
    end else if (!psel) begin
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = 32'h0;
    end

    // Register writes; all eight bits stored, spare ones too
    if (wr_en) begin
      unique case (word_index)
        `OCC_IDX_DRV_STD: begin
          nxt_state.regs.drv_std = write_byte(state_ff.regs.drv_std, pwdata, pstrb[0]);
        end
        `OCC_IDX_PIN_MODE: begin
          nxt_state.regs.pin_mode = write_byte(state_ff.regs.pin_mode, pwdata, pstrb[0]);
        end
        `OCC_IDX_RATIO_HIGH: begin
          nxt_state.regs.ratio_high =
            write_byte(state_ff.regs.ratio_high, pwdata, pstrb[0]);
        end
        `OCC_IDX_RATIO_MID: begin
          nxt_state.regs.ratio_mid = write_byte(state_ff.regs.ratio_mid, pwdata, pstrb[0]);
        end
        `OCC_IDX_RATIO_LOW: begin
          nxt_state.regs.ratio_low = write_byte(state_ff.regs.ratio_low, pwdata, pstrb[0]);
        end
        `OCC_IDX_PHASE_STR: begin
          nxt_state.regs.phase_str = write_byte(state_ff.regs.phase_str, pwdata, pstrb[0]);
        end
        `OCC_IDX_DELAY: begin
          nxt_state.regs.delay = write_byte(state_ff.regs.delay, pwdata, pstrb[0]);
        end
        `OCC_IDX_SUPPLY: begin
          nxt_state.regs.supply = write_byte(state_ff.regs.supply, pwdata, pstrb[0]);
        end
        default: begin
          nxt_state.regs = state_ff.regs;
        end
      endcase
    end

    // Divide ratio: three registers, extension bits from mode reg
    nxt_state.cfg.divide_ratio[19:16] =
      state_ff.regs.ratio_high[`OCC_RATIO_HIGH_MSB:0];
    nxt_state.cfg.divide_ratio[15:8] = state_ff.regs.ratio_mid;
    nxt_state.cfg.divide_ratio[7:0] = state_ff.regs.ratio_low;
    nxt_state.cfg.divide_ratio[31:20] = 12'h000;
    if (EXT_RANGE) begin
      nxt_state.cfg.divide_ratio[33:32] =
        state_ff.regs.pin_mode[`OCC_MODE_RATIO_MSB:`OCC_MODE_RATIO_LSB];
    end else begin
      nxt_state.cfg.divide_ratio[33:32] = 2'h0;
    end

    // Coarse delay counted in VCO periods, full 0..63 range
    nxt_state.cfg.coarse_delay =
      state_ff.regs.delay[`OCC_DELAY_COARSE_MSB:0];

    // Fine delay: two-bit code, or three-bit on extended channel
    if (EXT_RANGE) begin
      nxt_state.cfg.fine_steps = {state_ff.regs.pin_mode[`OCC_MODE_FINE_EXT],
        state_ff.regs.delay[`OCC_DELAY_FINE_MSB:`OCC_DELAY_FINE_LSB]};
      // Codes above four are not defined; clamp to the longest
      if (nxt_state.cfg.fine_steps > `OCC_FINE_MAX_STEPS) begin
        nxt_state.cfg.fine_steps = `OCC_FINE_MAX_STEPS;
      end
    end else begin
      nxt_state.cfg.fine_steps = {1'b0,
        state_ff.regs.delay[`OCC_DELAY_FINE_MSB:`OCC_DELAY_FINE_LSB]};
    end
    nxt_state.cfg.fine_delay_ps =
      8'(nxt_state.cfg.fine_steps * `OCC_FINE_STEP_PS);

    // Single-ended phase and drive strength pass straight through
    nxt_state.cfg.phase_select =
      state_ff.regs.phase_str[`OCC_PHASE_MSB:`OCC_PHASE_LSB];
    // Value seven is what software is expected to write
    nxt_state.cfg.drive_strength = state_ff.regs.phase_str[`OCC_STRENGTH_MSB:0];

    // Supply level and driver standard decode
    nxt_state.cfg.supply_level_select = occ_supply_t'(
      state_ff.regs.supply[`OCC_SUPPLY_MSB:`OCC_SUPPLY_LSB]);
    nxt_state.cfg.driver_standard_select = occ_drv_std_t'(
      state_ff.regs.drv_std[`OCC_DRV_STD_MSB:0]);
    nxt_state.cfg.pin_mode =
      decode_pins(state_ff.regs.pin_mode[`OCC_MODE_PIN_MSB:0]);

    // Flag any code that the analogue side has no meaning for
    nxt_state.cfg.config_error =
      (nxt_state.cfg.pin_mode == OCC_PIN_INVALID) ||
      (nxt_state.cfg.supply_level_select == OCC_VDD_RSVD) ||
      (nxt_state.cfg.driver_standard_select == OCC_DRV_RSVD6) ||
      (nxt_state.cfg.driver_standard_select == OCC_DRV_RSVD7);
  end

  // State register; everything zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs from flops, pslverr gated by the access phase; pready is constant high
  assign prdata = state_ff.prdata;
  assign pslverr = state_ff.pslverr && access_phase;
  assign pready = 1'b1;
  assign cfg = state_ff.cfg;

  // Pin driver steering for the channel
  occ_pin_router u_router (
    .true_clock(true_clock),
    .complement_clock(complement_clock),
    .pin_mode(state_ff.cfg.pin_mode),
    .phase_select(state_ff.cfg.phase_select),
    .pins(pins)
  );

endmodule : occ_bank

// ---- hdl/occ_regs.svh ----
/*
  Register indices, field positions, reset values and timing figures
  for one output channel's configuration bank.
  Assumes a 32-bit APB slave in front: byte address = index * 4.
*/
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// Register indices; byte address is four times the index
`define OCC_IDX_DRV_STD 8'h46
`define OCC_IDX_PIN_MODE 8'h47
`define OCC_IDX_RATIO_HIGH 8'h48
`define OCC_IDX_RATIO_MID 8'h49
`define OCC_IDX_RATIO_LOW 8'h4A
`define OCC_IDX_PHASE_STR 8'h4B
`define OCC_IDX_DELAY 8'h4C
`define OCC_IDX_SUPPLY 8'h4D

// Reset value of every register
`define OCC_RST_VAL 8'h00

// Field positions
`define OCC_MODE_RATIO_MSB 7
`define OCC_MODE_RATIO_LSB 6
`define OCC_MODE_FINE_EXT 4
`define OCC_MODE_PIN_MSB 3
`define OCC_RATIO_HIGH_MSB 3
`define OCC_PHASE_MSB 7
`define OCC_PHASE_LSB 6
`define OCC_STRENGTH_MSB 2
`define OCC_DELAY_COARSE_MSB 5
`define OCC_DELAY_FINE_MSB 7
`define OCC_DELAY_FINE_LSB 6
`define OCC_SUPPLY_MSB 4
`define OCC_SUPPLY_LSB 3
`define OCC_DRV_STD_MSB 2

// Timing: fine delay step and its largest count; advised drive strength
`define OCC_FINE_STEP_PS 8'h1E
`define OCC_FINE_MAX_STEPS 3'h4
`define OCC_STRENGTH_ADVISED 3'h7

`endif

// ---- hdl/occ_pkg.sv ----
/*
  Types for the output clock configuration bank.
  Assumes occ_regs.svh supplies offsets and field positions.
*/
package occ_pkg;

  // Driver standard codes as stored in the register
  typedef enum logic [2:0] {
    OCC_DRV_LVDS = 3'h0,
    OCC_DRV_PECL_CM = 3'h1,
    OCC_DRV_CML = 3'h2,
    OCC_DRV_HCSL = 3'h3,
    OCC_DRV_LVDS_BOOST = 3'h4,
    OCC_DRV_PECL_NOCM = 3'h5,
    OCC_DRV_RSVD6 = 3'h6,
    OCC_DRV_RSVD7 = 3'h7
  } occ_drv_std_t;

  // Supply level codes
  typedef enum logic [1:0] {
    OCC_VDD_1V8 = 2'h0,
    OCC_VDD_2V5 = 2'h1,
    OCC_VDD_3V3 = 2'h2,
    OCC_VDD_RSVD = 2'h3
  } occ_supply_t;

  // Decoded pin configuration
  typedef enum logic [2:0] {
    OCC_PIN_DIFF_EXT,
    OCC_PIN_DIFF_PULLUP,
    OCC_PIN_SE_POS,
    OCC_PIN_SE_NEG,
    OCC_PIN_SE_BOTH,
    OCC_PIN_INVALID
  } occ_pin_mode_t;

  // Decoded channel configuration handed to the analogue side
  typedef struct packed {
    logic [33:0] divide_ratio;
    logic [5:0] coarse_delay;
    logic [2:0] fine_steps;
    logic [7:0] fine_delay_ps;
    logic [1:0] phase_select;
    logic [2:0] drive_strength;
    occ_supply_t supply_level_select;
    occ_drv_std_t driver_standard_select;
    occ_pin_mode_t pin_mode;
    logic config_error;
  } occ_cfg_t;

  // Output pin drive group
  typedef struct packed {
    logic positive_pin;
    logic positive_pin_oe;
    logic negative_pin;
    logic negative_pin_oe;
  } occ_pins_t;

  // Raw register contents
  typedef struct packed {
    logic [7:0] drv_std;
    logic [7:0] pin_mode;
    logic [7:0] ratio_high;
    logic [7:0] ratio_mid;
    logic [7:0] ratio_low;
    logic [7:0] phase_str;
    logic [7:0] delay;
    logic [7:0] supply;
  } occ_regfile_t;

  // Whole state of the bank
  typedef struct packed {
    occ_regfile_t regs;
    logic [31:0] prdata;
    logic pslverr;
    occ_cfg_t cfg;
  } occ_state_t;

endpackage : occ_pkg

// ---- hdl/occ_pin_router.sv ----
/*
  Pin router: steers the true and complement clocks onto the two
  output pins and enables the drivers per pin configuration.
  Assumes the clocks come from the output divider and that the
  mode and phase inputs are stable flops of the register bank.
*/
`timescale 1ns/1ps

module occ_pin_router (
  input wire logic true_clock,
  input wire logic complement_clock,
  input wire occ_pkg::occ_pin_mode_t pin_mode,
  input wire logic [1:0] phase_select,
  output occ_pkg::occ_pins_t pins
);
  import occ_pkg::*;

  logic pos_driver_source;
  logic neg_driver_source;

  // Phase selection; only meaningful in single-ended modes
  always_comb begin
    unique case (phase_select)
      2'h0: begin
        pos_driver_source = true_clock;
        neg_driver_source = complement_clock;
      end
      2'h1: begin
        pos_driver_source = true_clock;
        neg_driver_source = true_clock;
      end
      default: begin
        pos_driver_source = complement_clock;
        neg_driver_source = complement_clock;
      end
    endcase
  end

  // Mode decides which pins drive; clock paths stay combinational
  // on purpose, a flop here would resample the clock itself
  always_comb begin
    pins = '0;
    unique case (pin_mode)
      OCC_PIN_DIFF_EXT, OCC_PIN_DIFF_PULLUP: begin
        pins.positive_pin = true_clock;
        pins.negative_pin = complement_clock;
        pins.positive_pin_oe = 1'b1;
        pins.negative_pin_oe = 1'b1;
      end
      OCC_PIN_SE_POS: begin
        pins.positive_pin = pos_driver_source;
        pins.positive_pin_oe = 1'b1;
      end
      OCC_PIN_SE_NEG: begin
        pins.negative_pin = neg_driver_source;
        pins.negative_pin_oe = 1'b1;
      end
      OCC_PIN_SE_BOTH: begin
        pins.positive_pin = pos_driver_source;
        pins.negative_pin = neg_driver_source;
        pins.positive_pin_oe = 1'b1;
        pins.negative_pin_oe = 1'b1;
      end
      default: begin
        pins = '0; // Illegal mode: both drivers off
      end
    endcase
  end

endmodule : occ_pin_router

// ---- testbench/occ_bank_properties.sv ----
/* Checker for occ_bank: APB answer, config decode and pin steering.
   Assumes it is bound to occ_bank and sees one pclk domain. */
`timescale 1ns/1ps
`include "occ_regs.svh"

module occ_bank_properties import occ_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic true_clock,
  input wire logic complement_clock,
  input wire occ_cfg_t cfg,
  input wire occ_pins_t pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode nibble decode, illegal codes fall to invalid
  function automatic occ_pin_mode_t mode_of(input logic [3:0] m);
    case (m)
      4'h0: return OCC_PIN_DIFF_EXT;
      4'h2: return OCC_PIN_DIFF_PULLUP;
      4'h4: return OCC_PIN_SE_POS;
      4'h8: return OCC_PIN_SE_NEG;
      4'hC: return OCC_PIN_SE_BOTH;
      default: return OCC_PIN_INVALID;
    endcase
  endfunction : mode_of
  // Accepted write to one register index
  sequence s_wr(idx);
    psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'h0 && paddr[ADDR_W-1:2] == idx;
  endsequence
  // Unmapped or unaligned setup
  sequence s_bad;
    psel && !penable && (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:2] < `OCC_IDX_DRV_STD ||
      paddr[ADDR_W-1:2] > `OCC_IDX_SUPPLY);
  endsequence
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    pslverr == (psel && penable && (paddr[1:0] != 2'h0 ||
      paddr[ADDR_W-1:2] < `OCC_IDX_DRV_STD || paddr[ADDR_W-1:2] > `OCC_IDX_SUPPLY));
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_bad; s_bad |=> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("bad address accepted");
  property p_low;
    s_wr(`OCC_IDX_RATIO_LOW) |-> ##2 cfg.divide_ratio[7:0] == $past(pwdata[7:0], 2);
  endproperty
  a_low: assert property (p_low) else $error("ratio low byte wrong");
  property p_mid;
    s_wr(`OCC_IDX_RATIO_MID) |-> ##2 cfg.divide_ratio[15:8] == $past(pwdata[7:0], 2);
  endproperty
  a_mid: assert property (p_mid) else $error("ratio mid byte wrong");
  property p_high;
    s_wr(`OCC_IDX_RATIO_HIGH) |-> ##2 cfg.divide_ratio[19:16] == $past(pwdata[3:0], 2);
  endproperty
  a_high: assert property (p_high) else $error("ratio high nibble wrong");
  property p_mode;
    s_wr(`OCC_IDX_PIN_MODE) |-> ##2 cfg.divide_ratio[33:32] == $past(pwdata[7:6], 2) &&
      cfg.pin_mode == mode_of($past(pwdata[3:0], 2));
  endproperty
  a_mode: assert property (p_mode) else $error("mode register decode wrong");
  property p_coarse;
    s_wr(`OCC_IDX_DELAY) |-> ##2 cfg.coarse_delay == $past(pwdata[5:0], 2);
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse delay wrong");
  property p_fine;
    cfg.fine_steps <= 3'h4 && cfg.fine_delay_ps == cfg.fine_steps * 8'h1E;
  endproperty
  a_fine: assert property (p_fine) else $error("fine delay wrong");
  property p_phase;
    cfg.pin_mode == OCC_PIN_SE_BOTH && cfg.phase_select == 2'h1 |->
      pins.positive_pin == true_clock && pins.negative_pin == true_clock;
  endproperty
  a_phase: assert property (p_phase) else $error("phase routing wrong");
  property p_std;
    s_wr(`OCC_IDX_DRV_STD) |-> ##2 cfg.driver_standard_select == $past(pwdata[2:0], 2);
  endproperty
  a_std: assert property (p_std) else $error("driver standard wrong");
  property p_vdd;
    s_wr(`OCC_IDX_SUPPLY) |-> ##2 cfg.supply_level_select == $past(pwdata[4:3], 2);
  endproperty
  a_vdd: assert property (p_vdd) else $error("supply level wrong");
endmodule : occ_bank_properties

bind occ_bank occ_bank_properties #(.ADDR_W(ADDR_W)) u_occ_bank_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .true_clock(true_clock), .complement_clock(complement_clock),
  .cfg(cfg), .pins(pins));

// ---- testbench/tb_top.sv ----
/* Self-checking bench for occ_bank over APB.
   Assumes occ_regs.svh indices and a zero-wait APB slave. */
`timescale 1ns/1ps
`include "occ_regs.svh"

module tb_top;
  import occ_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic true_clock = 1'b1;
  logic complement_clock = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  occ_cfg_t cfg;
  occ_pins_t pins;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic er;
  // 10 MHz clock
  always #50 pclk = ~pclk;
  occ_bank u_occ_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .true_clock(true_clock),
    .complement_clock(complement_clock), .cfg(cfg), .pins(pins));
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad
  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer; outputs read before the edge's updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Write, then let the decoded config follow one edge later
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, ad(i), {24'hABCDEF, d}, 4'hF);
    repeat (2) @(posedge pclk);
  endtask : wr
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ad(`OCC_IDX_DRV_STD + i), 32'h0, 4'hF);
      chk("reset value", 34'h0, rd);
    end
    chk("reset pin mode", OCC_PIN_DIFF_EXT, cfg.pin_mode);
    chk("reset oe", 34'h3, {pins.positive_pin_oe, pins.negative_pin_oe});
  endtask : t_reset
  task automatic t_rw();
    for (int i = 0; i < 8; i++) begin
      wr(`OCC_IDX_DRV_STD + i, 8'hA0 + i);
      apb(1'b0, ad(`OCC_IDX_DRV_STD + i), 32'h0, 4'hF);
      chk("readback", 34'hA0 + i, rd);
    end
    apb(1'b1, ad(`OCC_IDX_RATIO_LOW), 32'h11, 4'h0);
    apb(1'b1, ad(`OCC_IDX_RATIO_LOW) + 12'h1, 32'h22, 4'hF);
    chk("unaligned error", 34'h1, er);
    apb(1'b0, ad(8'h45), 32'h0, 4'hF);
    chk("unmapped error", 34'h1, er);
    chk("unmapped data", 34'h0, rd);
    apb(1'b0, ad(`OCC_IDX_RATIO_LOW), 32'h0, 4'hF);
    chk("ignored write", 34'hA4, rd);
  endtask : t_rw
  task automatic t_ratio();
    wr(`OCC_IDX_RATIO_HIGH, 8'hA5);
    wr(`OCC_IDX_RATIO_MID, 8'h3C);
    wr(`OCC_IDX_RATIO_LOW, 8'h96);
    wr(`OCC_IDX_PIN_MODE, 8'hC0);
    chk("divide ratio", 34'h300053C96, cfg.divide_ratio);
  endtask : t_ratio
  task automatic t_delay();
    wr(`OCC_IDX_PIN_MODE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`OCC_IDX_DELAY, {k[1:0], (k == 0) ? 6'h3F : 6'h00});
      chk("coarse", (k == 0) ? 34'h3F : 34'h0, cfg.coarse_delay);
      chk("fine ps", k * 30, cfg.fine_delay_ps);
    end
    wr(`OCC_IDX_DELAY, 8'h00);
    wr(`OCC_IDX_PIN_MODE, 8'h10);
    chk("fine steps", 34'h4, cfg.fine_steps);
    chk("fine ps ext", 34'd120, cfg.fine_delay_ps);
    // Undefined codes above four clamp to four steps
    wr(`OCC_IDX_DELAY, 8'hC0);
    chk("fine clamp", 34'h4, cfg.fine_steps);
  endtask : t_delay
  task automatic t_pins();
    logic [3:0] code [5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hC};
    occ_pin_mode_t mode [5] = '{OCC_PIN_DIFF_EXT, OCC_PIN_DIFF_PULLUP, OCC_PIN_SE_POS,
                                OCC_PIN_SE_NEG, OCC_PIN_SE_BOTH};
    logic [1:0] oe [5] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h3};
    for (int i = 0; i < 5; i++) begin
      wr(`OCC_IDX_PIN_MODE, {4'h0, code[i]});
      chk("pin mode", mode[i], cfg.pin_mode);
      chk("pin oe", oe[i], {pins.positive_pin_oe, pins.negative_pin_oe});
    end
    // Phase table with true high, complement low
    for (int p = 0; p < 4; p++) begin
      wr(`OCC_IDX_PHASE_STR, {p[1:0], 6'h07});
      chk("pin levels", (p == 0) ? 2'h2 : (p == 1) ? 2'h3 : 2'h0,
          {pins.positive_pin, pins.negative_pin});
      chk("strength", 34'h7, cfg.drive_strength);
    end
    wr(`OCC_IDX_PIN_MODE, 8'h01);
    chk("invalid mode", OCC_PIN_INVALID, cfg.pin_mode);
    chk("invalid oe", 34'h0, {pins.positive_pin_oe, pins.negative_pin_oe});
    chk("config error", 34'h1, cfg.config_error);
  endtask : t_pins
  task automatic t_codes();
    for (int c = 0; c < 6; c++) begin
      wr(`OCC_IDX_DRV_STD, c[7:0]);
      chk("driver standard", c, cfg.driver_standard_select);
    end
    for (int v = 0; v < 3; v++) begin
      wr(`OCC_IDX_SUPPLY, {3'h0, v[1:0], 3'h0});
      chk("supply", v, cfg.supply_level_select);
    end
    // Legal codes clear the error flag, reserved ones raise it
    wr(`OCC_IDX_PIN_MODE, 8'h00);
    chk("config error", 34'h0, cfg.config_error);
    wr(`OCC_IDX_DRV_STD, 8'h07);
    chk("config error", 34'h1, cfg.config_error);
    wr(`OCC_IDX_DRV_STD, 8'h05);
    wr(`OCC_IDX_SUPPLY, 8'h18);
    chk("config error", 34'h1, cfg.config_error);
  endtask : t_codes
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_ratio();
    t_delay();
    t_pins();
    t_codes();
    // Second reset in mid-run clears the bank again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    summarize();
  end
endmodule : tb_top
